// ### design/rtcc_spi_front.v
// Operation
// - Low chip select selects; high deselects and ignores serial activity.
// - A started programming cycle completes whatever chip select does.
// - Serial output released to high impedance while deselected.
// - No command accepted until a chip select falling edge after power-up.
// - Input sampled on clock rise; output changes after clock fall.
// - First eight received bits form the instruction byte.
// - All bytes shifted most significant bit first.
// - First bit sampled on first clock rise after select falls.
// - Codes 03 and 02 read and write the EEPROM array.
// - Code 06 sets, code 04 clears the write-enable latch.
// - Codes 13 and 12 read and write the clock and SRAM space.
// - Code 14 unlocks the protected block for a following write.
// - Codes 32 and 33 write and read the protected block.
// - Code 54 clears all SRAM; code 44 clears the watchdog count.
// - Watchdog pin idles high, pulses low on overflow, selectable width.
// - Alarm routed to watchdog pin gives a low pulse per trigger.
// - Event detection holds interrupt pin low until its flag clears.
// - Routed alarm holds interrupt pin low until alarm flag clears.
// - External oscillator mode takes timekeeping clock from crystal input.
// - Clock registers at 00-1F, SRAM at 20-5F in shared space.
// - Out-of-range addresses get no response.
// - Programming starts at select rise after a valid non-clock-space write when not busy, ends within 5 ms.
`include "rtcc_spi_map.vh"
`timescale 1ns/1ps
module rtcc_spi_front #(
	parameter WRITE_CYC = `WRITE_CYCLE_CYC
)(
	input wire I_CLK_SYS,
	input wire I_NRST,
	input wire i_cs_n,
	input wire i_sck,
	input wire i_si,
	output wire o_so,
	output wire o_so_oe,
	input wire i_rd_data_valid,
	input wire [7:0] i_rd_data,
	output wire o_rd_data_ready,
	output wire o_wr_valid,
	input wire i_wr_ready,
	output wire [1:0] o_wr_space,
	output wire [7:0] o_wr_addr,
	output wire [7:0] o_wr_data,
	output reg o_rd_req,
	output reg [1:0] o_rd_space,
	output reg [7:0] o_rd_addr,
	output reg o_prog_start,
	output wire o_prog_busy,
	output reg o_wdt_clear,
	output reg o_sram_clear,
	output wire o_write_latch,
	output wire o_unlocked,
	input wire i_wdt_overflow,
	input wire [7:0] i_wdt_pulse_cyc,
	input wire i_alarm_to_wdo,
	input wire i_alarm_trig,
	input wire i_event_flag,
	input wire i_alarm_flag,
	input wire i_alarm_to_irq,
	output wire o_watchdog_out_n_oe,
	output wire o_watchdog_out_n,
	output wire o_irq_n_oe,
	output wire o_irq_n,
	input wire i_ext_osc_sel,
	input wire i_crystal_in,
	input wire i_osc_clk,
	output wire o_timekeep_clk
);
	localparam SPACE_EEPROM = 2'd0;
	localparam SPACE_CLOCK = 2'd1;
	localparam SPACE_PROT = 2'd2;
	localparam SPACE_STATUS = 2'd3;
	localparam ST_CMD = 4'b0001;
	localparam ST_ADDR = 4'b0010;
	localparam ST_DATA = 4'b0100;
	localparam ST_IDLE = 4'b1000;

	wire cs_n_s;
	wire sck_s;
	wire si_s;
	reg cs_d_r;
	reg sck_d_r;
	reg armed_r;
	reg [3:0] st_r;
	reg [3:0] st_nxt;
	reg [2:0] bit_r;
	reg [7:0] sh_r;
	reg [7:0] cmd_r;
	reg [7:0] addr_r;
	reg is_write_r;
	reg is_read_r;
	reg [1:0] space_r;
	reg wel_r;
	reg unlock_r;
	reg wr_pend_r;
	reg [7:0] tx_r;
	reg so_r;
	reg busy_r;
	reg [22:0] prog_cnt_r;
	reg [7:0] wdo_cnt_r;
	reg wdt_pend_r;
	reg wr_push_r;
	reg [17:0] wr_word_r;

	wire sel_fall = cs_d_r && !cs_n_s;
	wire sel_rise = !cs_d_r && cs_n_s;
	wire selected = !cs_n_s && armed_r;
	wire sck_rise = selected && !sck_d_r && sck_s;
	wire sck_fall = selected && sck_d_r && !sck_s;
	wire [7:0] byte_in = {sh_r[6:0], si_s};
	wire byte_done = sck_rise && (bit_r == 3'd7);

	// Pins pass two flops before use; select path resets low so a pin held
	// low through reset never shows a false falling edge
	rtcc_sync2 #(.RESET_VAL(1'b0)) u_cs (.i_clk(I_CLK_SYS), .i_nrst(I_NRST),
		.i_async(i_cs_n), .o_sync(cs_n_s));
	rtcc_sync2 #(.RESET_VAL(1'b0)) u_sck (.i_clk(I_CLK_SYS), .i_nrst(I_NRST),
		.i_async(i_sck), .o_sync(sck_s));
	rtcc_sync2 #(.RESET_VAL(1'b0)) u_si (.i_clk(I_CLK_SYS), .i_nrst(I_NRST),
		.i_async(i_si), .o_sync(si_s));

	// Write words queue toward the memory side
	rtcc_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(3)) u_wr_fifo (
		.i_clk(I_CLK_SYS), .i_nrst(I_NRST),
		.i_valid(wr_push_r), .o_ready(),
		.i_data(wr_word_r),
		.o_valid(o_wr_valid), .i_ready(i_wr_ready && !busy_r),
		.o_data({o_wr_space, o_wr_addr, o_wr_data}));

	// Range check per space
	function in_range;
		input [1:0] sp;
		input [7:0] a;
		begin
			case (sp)
				SPACE_CLOCK: in_range = (a <= `SRAM_LAST);
				SPACE_PROT: in_range = (a <= `PROT_LAST);
				default: in_range = 1'b1;
			endcase
		end
	endfunction

	// Transaction sequencer
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
			ST_CMD:
				if (byte_done)
					st_nxt = (is_cmd_addr(byte_in)) ? ST_ADDR :
						(byte_in == `CMD_STATUS_READ || byte_in == `CMD_STATUS_WRITE) ?
						ST_DATA : ST_IDLE;
			ST_ADDR:
				if (byte_done)
					st_nxt = in_range(space_r, byte_in) ? ST_DATA : ST_IDLE;
			ST_DATA: st_nxt = ST_DATA;
			ST_IDLE: st_nxt = ST_IDLE;
			default: st_nxt = ST_CMD;
		endcase
		if (!selected)
			st_nxt = ST_CMD;
	end

	function is_cmd_addr;
		input [7:0] c;
		begin
			is_cmd_addr = (c == `CMD_EEPROM_READ) || (c == `CMD_EEPROM_WRITE) ||
				(c == `CMD_CLOCK_READ) || (c == `CMD_CLOCK_WRITE) ||
				(c == `CMD_PROT_READ) || (c == `CMD_PROT_WRITE);
		end
	endfunction

	// Serial front end and decoder
	always @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
		begin
			cs_d_r <= 1'b0;
			sck_d_r <= 1'b0;
			armed_r <= 1'b0;
			st_r <= ST_CMD;
			bit_r <= 3'd0;
			sh_r <= 8'h00;
			cmd_r <= 8'h00;
			addr_r <= 8'h00;
			is_write_r <= 1'b0;
			is_read_r <= 1'b0;
			space_r <= SPACE_EEPROM;
			wel_r <= 1'b0;
			unlock_r <= 1'b0;
			wr_pend_r <= 1'b0;
			tx_r <= 8'h00;
			so_r <= 1'b0;
			o_rd_req <= 1'b0;
			o_rd_space <= SPACE_EEPROM;
			o_rd_addr <= 8'h00;
			o_wdt_clear <= 1'b0;
			o_sram_clear <= 1'b0;
			o_prog_start <= 1'b0;
			wr_push_r <= 1'b0;
			wr_word_r <= 18'h00000;
		end
		else
		begin
			cs_d_r <= cs_n_s;
			sck_d_r <= sck_s;
			st_r <= st_nxt;
			o_rd_req <= 1'b0;
			o_wdt_clear <= 1'b0;
			o_sram_clear <= 1'b0;
			o_prog_start <= 1'b0;
			wr_push_r <= 1'b0;
			if (sel_fall)
				armed_r <= 1'b1;
			if (!selected)
			begin
				bit_r <= 3'd0;
				sh_r <= 8'h00;
			end
			else if (sck_rise)
			begin
				sh_r <= byte_in;
				bit_r <= bit_r + 3'd1;
			end
			if (st_r == ST_CMD && byte_done)
			begin
				cmd_r <= byte_in;
				is_read_r <= 1'b0;
				is_write_r <= 1'b0;
				case (byte_in)
					`CMD_EEPROM_READ: begin space_r <= SPACE_EEPROM; is_read_r <= 1'b1; end
					`CMD_EEPROM_WRITE:
					begin
						space_r <= SPACE_EEPROM;
						is_write_r <= wel_r;
					end
					`CMD_LATCH_SET: wel_r <= 1'b1;
					`CMD_LATCH_CLEAR: wel_r <= 1'b0;
					`CMD_CLOCK_READ: begin space_r <= SPACE_CLOCK; is_read_r <= 1'b1; end
					`CMD_CLOCK_WRITE: begin space_r <= SPACE_CLOCK; is_write_r <= 1'b1; end
					`CMD_UNLOCK: unlock_r <= 1'b1;
					`CMD_PROT_READ: begin space_r <= SPACE_PROT; is_read_r <= 1'b1; end
					`CMD_PROT_WRITE:
					begin
						space_r <= SPACE_PROT;
						is_write_r <= wel_r && unlock_r;
					end
					`CMD_STATUS_READ:
					begin
						space_r <= SPACE_STATUS;
						is_read_r <= 1'b1;
						o_rd_req <= 1'b1;
						o_rd_space <= SPACE_STATUS;
						o_rd_addr <= 8'h00;
					end
					`CMD_STATUS_WRITE: begin space_r <= SPACE_STATUS; is_write_r <= wel_r; end
					`CMD_WDT_CLEAR: o_wdt_clear <= 1'b1;
					`CMD_SRAM_CLEAR: o_sram_clear <= 1'b1;
					default: ;
				endcase
			end
			if (st_r == ST_ADDR && byte_done)
			begin
				addr_r <= byte_in;
				if (is_read_r && in_range(space_r, byte_in))
				begin
					o_rd_req <= 1'b1;
					o_rd_space <= space_r;
					o_rd_addr <= byte_in;
				end
			end
			if (st_r == ST_DATA && byte_done)
			begin
				if (is_write_r && in_range(space_r, addr_r))
				begin
					wr_push_r <= 1'b1;
					wr_word_r <= {space_r, addr_r, byte_in};
					wr_pend_r <= (space_r != SPACE_CLOCK);
				end
				if (is_read_r && space_r != SPACE_STATUS && in_range(space_r, addr_r + 8'd1))
				begin
					o_rd_req <= 1'b1;
					o_rd_space <= space_r;
					o_rd_addr <= addr_r + 8'd1;
				end
				addr_r <= addr_r + 8'd1;
			end
			// Load next read byte
			if (i_rd_data_valid)
				tx_r <= i_rd_data;
			if (sck_fall && st_r == ST_DATA && is_read_r)
			begin
				so_r <= tx_r[7 - bit_r];
			end
			if (sel_rise && wr_pend_r && !busy_r)
			begin
				o_prog_start <= 1'b1;
				wr_pend_r <= 1'b0;
				wel_r <= 1'b0;
				unlock_r <= 1'b0;
			end
			else if (sel_rise)
				wr_pend_r <= 1'b0;
		end
	end

	assign o_rd_data_ready = 1'b1;
	assign o_write_latch = wel_r;
	assign o_unlocked = unlock_r;
	assign o_so = so_r;
	assign o_so_oe = selected && st_r == ST_DATA && is_read_r;

	always @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
		begin
			busy_r <= 1'b0;
			prog_cnt_r <= 23'd0;
		end
		else if (o_prog_start)
		begin
			busy_r <= 1'b1;
			prog_cnt_r <= WRITE_CYC[22:0] - 23'd1;
		end
		else if (busy_r)
		begin
			if (prog_cnt_r == 23'd0)
				busy_r <= 1'b0;
			else
				prog_cnt_r <= prog_cnt_r - 23'd1;
		end
	end
	assign o_prog_busy = busy_r;

	always @(posedge I_CLK_SYS)
	begin
		if (!I_NRST)
		begin
			wdo_cnt_r <= 8'h00;
			wdt_pend_r <= 1'b0;
		end
		else if (wdo_cnt_r == 8'h00 &&
			(i_wdt_overflow || (i_alarm_to_wdo && i_alarm_trig)))
			wdo_cnt_r <= (i_wdt_pulse_cyc == 8'h00) ? 8'h01 : i_wdt_pulse_cyc;
		else if (wdo_cnt_r != 8'h00)
			wdo_cnt_r <= wdo_cnt_r - 8'h01;
	end
	assign o_watchdog_out_n = 1'b0;
	assign o_watchdog_out_n_oe = (wdo_cnt_r != 8'h00);

	assign o_irq_n = 1'b0;
	assign o_irq_n_oe = i_event_flag || (i_alarm_to_irq && i_alarm_flag);

	assign o_timekeep_clk = i_ext_osc_sel ? i_crystal_in : i_osc_clk;
endmodule

// ### design/rtcc_spi_map.vh
`ifndef RTCC_SPI_MAP_VH
`define RTCC_SPI_MAP_VH

// Instruction codes
`define CMD_EEPROM_WRITE 8'h02
`define CMD_EEPROM_READ 8'h03
`define CMD_LATCH_CLEAR 8'h04
`define CMD_LATCH_SET 8'h06
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_CLOCK_WRITE 8'h12
`define CMD_CLOCK_READ 8'h13
`define CMD_UNLOCK 8'h14
`define CMD_PROT_WRITE 8'h32
`define CMD_PROT_READ 8'h33
`define CMD_WDT_CLEAR 8'h44
`define CMD_SRAM_CLEAR 8'h54

// Address ranges
`define CLK_REG_LAST 8'h1F
`define SRAM_FIRST 8'h20
`define SRAM_LAST 8'h5F
`define EEPROM_LAST 8'hFF
`define PROT_LAST 8'h0F

// Reset values
`define STATUS_RESET 8'h00

// Timing
`define SYS_CLK_MHZ 250
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLE_CYC (`WRITE_CYCLE_MS * 1000 * `SYS_CLK_MHZ)

// FIFO shape
`define FIFO_WIDTH 18
`define FIFO_DEPTH 8

`endif

// ### design/rtcc_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for one pin level
module rtcc_sync2 #(
	parameter RESET_VAL = 1'b0
)(
	input wire i_clk,
	input wire i_nrst,
	input wire i_async,
	output wire o_sync
);
	reg meta_r;
	reg sync_r;

	// First stage is read only by the second
	always @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
		end
		else
		begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;
endmodule

// ### design/rtcc_fifo.v
`timescale 1ns/1ps
// Synchronous FIFO with valid and ready on both sides
module rtcc_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
)(
	input wire i_clk,
	input wire i_nrst,
	input wire i_valid,
	output wire o_ready,
	input wire [WIDTH-1:0] i_data,
	output wire o_valid,
	input wire i_ready,
	output wire [WIDTH-1:0] o_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_r;
	reg [AW-1:0] rd_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;

	assign o_ready = (cnt_r != DEPTH[AW:0]);
	assign o_valid = (cnt_r != {(AW+1){1'b0}});
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	assign o_data = mem[rd_r];

	// Storage write
	always @(posedge i_clk)
	begin
		if (push)
			mem[wr_r] <= i_data;
	end

	// Pointers and fill count
	always @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			wr_r <= {AW{1'b0}};
			rd_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// ### sim/rtcc_spi_checker.sv
`timescale 1ns/1ps
// Watches the serial pins, command pulses and open-drain enables
module rtcc_spi_checker #(
	parameter WRITE_CYC = 50
)(
	input wire I_CLK_SYS,
	input wire I_NRST,
	input wire i_cs_n,
	input wire i_sck,
	input wire o_so,
	input wire o_so_oe,
	input wire o_rd_req,
	input wire o_prog_busy,
	input wire o_wdt_clear,
	input wire i_wdt_overflow,
	input wire [7:0] i_wdt_pulse_cyc,
	input wire i_alarm_to_wdo,
	input wire i_alarm_trig,
	input wire i_event_flag,
	input wire i_alarm_flag,
	input wire i_alarm_to_irq,
	input wire o_watchdog_out_n_oe,
	input wire o_irq_n_oe,
	input wire i_ext_osc_sel,
	input wire i_crystal_in,
	input wire i_osc_clk,
	input wire o_timekeep_clk
);
	reg [31:0] busy_r;
	reg [7:0] low_r;
	wire [7:0] exp_w = (i_wdt_pulse_cyc == 8'h00) ? 8'h01 : i_wdt_pulse_cyc;
	// Run lengths of busy and of the pulled-low watchdog pin
	always @(posedge I_CLK_SYS)
	begin
		busy_r <= o_prog_busy ? busy_r + 32'h1 : 32'h0;
		low_r <= o_watchdog_out_n_oe ? low_r + 8'h1 : 8'h0;
	end
	default clocking dc @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_NRST);
	sequence s_idle;
		i_cs_n [*5];
	endsequence
	sequence s_wdo_end;
		$fell(o_watchdog_out_n_oe) && !i_alarm_to_wdo;
	endsequence
	property p_so_hiz;
		s_idle |-> !o_so_oe;
	endproperty
	a_so_hiz: assert property (p_so_hiz) else $error("so driven idle");
	property p_so_fall;
		$changed(o_so) && o_so_oe && $past(o_so_oe) |-> !i_sck;
	endproperty
	a_so_fall: assert property (p_so_fall) else $error("so moved sck high");
	property p_req_sel;
		o_rd_req |-> !i_cs_n;
	endproperty
	a_req_sel: assert property (p_req_sel) else $error("read while idle");
	property p_busy_len;
		$fell(o_prog_busy) |-> busy_r >= WRITE_CYC - 1 && busy_r <= WRITE_CYC;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_wdt_once;
		o_wdt_clear |=> !o_wdt_clear;
	endproperty
	a_wdt_once: assert property (p_wdt_once) else $error("clear pulse long");
	property p_wdo_go;
		i_wdt_overflow |-> ##[1:2] o_watchdog_out_n_oe;
	endproperty
	a_wdo_go: assert property (p_wdo_go) else $error("no wdo pulse");
	property p_wdo_width;
		s_wdo_end |-> low_r == exp_w;
	endproperty
	a_wdo_width: assert property (p_wdo_width) else $error("wdo width");
	property p_wdo_alarm;
		i_alarm_to_wdo && i_alarm_trig |-> ##[1:2] o_watchdog_out_n_oe;
	endproperty
	a_wdo_alarm: assert property (p_wdo_alarm) else $error("no alarm pulse");
	property p_irq_ev;
		i_event_flag |-> o_irq_n_oe;
	endproperty
	a_irq_ev: assert property (p_irq_ev) else $error("irq not low");
	property p_irq_al;
		i_alarm_flag && i_alarm_to_irq |-> o_irq_n_oe;
	endproperty
	a_irq_al: assert property (p_irq_al) else $error("alarm irq");
	property p_tk;
		o_timekeep_clk == (i_ext_osc_sel ? i_crystal_in : i_osc_clk);
	endproperty
	a_tk: assert property (p_tk) else $error("clock source");
endmodule

bind rtcc_spi_front rtcc_spi_checker #(.WRITE_CYC(WRITE_CYC)) chk (.*);

// ### sim/rtcc_host_model.sv
`timescale 1ns/1ps
// Serial host; clock idles low between frames
module rtcc_host_model (
	input wire i_clk,
	input wire i_so,
	output reg o_cs_n = 1'b0,
	output reg o_sck = 1'b0,
	output reg o_si = 1'b0
);
	reg [7:0] rx = 8'h00;
	// Half of the 80 ns link period
	task half;
		repeat (10) @(posedge i_clk);
	endtask
	task open;
		begin
			o_cs_n <= 1'b0;
			half;
		end
	endtask
	task xfer(input [7:0] tx);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
			begin
				o_si <= tx[i];
				half;
				o_sck <= 1'b1;
				rx[i] <= i_so;
				half;
				o_sck <= 1'b0;
			end
		end
	endtask
	// select held to the last bit
	task close;
		begin
			half;
			o_cs_n <= 1'b1;
			o_si <= ~o_si;
			half;
		end
	endtask
endmodule

// ### sim/rtcc_spi_command_front_end_bench.sv
`timescale 1ns/1ps
`include "rtcc_spi_map.vh"
module rtcc_spi_command_front_end_bench;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg rdv = 1'b0;
	reg wrr = 1'b1;
	reg [1:0] wmode = 2'd0;
	reg [1:0] osc = 2'b00;
	reg [7:0] pw = 8'h05;
	wire [1:0] ws;
	wire busy;
	reg [9:0] pin = 10'h000;
	reg [7:0] rdd = 8'h00;
	reg [7:0] req_sp, req_ad, a, d;
	reg [7:0] dat [0:7];
	reg [31:0] r;
	reg [17:0] wq [$];
	integer err_total = 0;
	integer num_checks = 0;
	integer n_req = 0;
	integer n_prog = 0;
	integer n_wdt = 0;
	integer n_ram = 0;
	integer cyc = 0;
	integer i, k, s;
	wire cs_n, sck, si, so, so_oe, wr_v, req, prog, wclr, sclr, latch, unl, irq_oe;
	wire [1:0] rd_sp;
	wire [7:0] rd_ad, wa, wd;
	rtcc_spi_front #(.WRITE_CYC(300)) uut (.I_CLK_SYS(clk), .I_NRST(nrst),
		.i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so), .o_so_oe(so_oe),
		.i_rd_data_valid(rdv), .i_rd_data(rdd), .o_rd_data_ready(), .o_wr_valid(wr_v),
		.i_wr_ready(wrr), .o_wr_space(ws), .o_wr_addr(wa), .o_wr_data(wd), .o_rd_req(req),
		.o_rd_space(rd_sp), .o_rd_addr(rd_ad), .o_prog_start(prog), .o_prog_busy(busy),
		.o_wdt_clear(wclr), .o_sram_clear(sclr), .o_write_latch(latch), .o_unlocked(unl),
		.i_wdt_overflow(pin[0]), .i_wdt_pulse_cyc(pw), .i_alarm_to_wdo(pin[1]),
		.i_alarm_trig(pin[2]), .i_event_flag(pin[3]), .i_alarm_flag(pin[4]),
		.i_alarm_to_irq(pin[5]), .o_watchdog_out_n_oe(), .o_watchdog_out_n(),
		.o_irq_n_oe(irq_oe), .o_irq_n(), .i_ext_osc_sel(pin[6]), .i_crystal_in(osc[0]),
		.i_osc_clk(osc[1]), .o_timekeep_clk());
	rtcc_host_model h (.i_clk(clk), .i_so(so_oe ? so : ~so), .o_cs_n(cs_n), .o_sck(sck),
		.o_si(si));
	initial
	begin
		forever #2 clk = ~clk;
	end
	// Memory side, pulse counts, write drain and hang limit
	always @(posedge clk)
	begin
		r = $urandom;
		rdv <= req;
		osc <= {~osc[1], r[0]};
		cyc <= cyc + 1;
		// Ready: 0 always, 1 never, 2 random
		wrr <= wmode[1] ? r[1] : !wmode[0];
		if (req === 1'b1)
		begin
			n_req <= n_req + 1;
			req_sp <= rd_sp;
			req_ad <= rd_ad;
		end
		n_prog <= n_prog + (prog === 1'b1);
		n_wdt <= n_wdt + (wclr === 1'b1);
		n_ram <= n_ram + (sclr === 1'b1);
		if (wr_v && wrr && !busy)
			wq.push_back({ws, wa, wd});
		if (cyc == 40000)
		begin
			err_total = err_total + 1;
			conclude;
		end
	end
	task chk(input [17:0] got, input [17:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp)
			begin
				err_total = err_total + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task conclude;
		begin
			if (err_total == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task cmd(input [7:0] c);
		begin
			h.open;
			h.xfer(c);
			h.close;
		end
	endtask
	// Instruction, address and one data byte in one selection
	task op3(input [7:0] c, input [7:0] x, input [7:0] y);
		begin
			h.open;
			h.xfer(c);
			h.xfer(x);
			h.xfer(y);
			h.close;
		end
	endtask
	initial
	begin
		s = $urandom(32'h4749);
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		h.xfer(`CMD_LATCH_SET);
		h.close;
		chk(latch, 0);
		cmd(`CMD_LATCH_SET);
		chk(latch, 1);
		cmd(`CMD_LATCH_CLEAR);
		chk(latch, 0);
		op3(`CMD_EEPROM_WRITE, 8'h40, 8'h5A);
		chk(n_prog, 0);
		for (k = 0; k < 2; k = k + 1)
		begin
			a = $urandom;
			a = k ? a & `PROT_LAST : a;
			d = $urandom;
			cmd(`CMD_LATCH_SET);
			if (k)
				cmd(`CMD_UNLOCK);
			chk(unl, k);
			op3(k ? `CMD_PROT_WRITE : `CMD_EEPROM_WRITE, a, d);
			chk(latch, 0);
			cmd(`CMD_WDT_CLEAR);
			repeat (300) @(posedge clk);
			chk(n_prog, k + 1);
			chk(wq.pop_front(), {(k ? 2'd2 : 2'd0), a, d});
		end
		chk(n_wdt, 2);
		wmode <= 2'd1;
		a = 8'h20 + $urandom % 56;
		h.open;
		h.xfer(`CMD_CLOCK_WRITE);
		h.xfer(a);
		for (i = 0; i < 8; i = i + 1)
		begin
			dat[i] = $urandom;
			h.xfer(dat[i]);
		end
		h.close;
		chk(wq.size(), 0);
		wmode <= 2'd2;
		repeat (100) @(posedge clk);
		for (i = 0; i < 8; i = i + 1)
			chk(wq.pop_front(), {2'd1, a + i[7:0], dat[i]});
		chk(n_prog, 2);
		for (k = 0; k < 3; k = k + 1)
		begin
			d = k == 0 ? `EEPROM_LAST : k == 1 ? `SRAM_LAST : `PROT_LAST;
			a = $urandom;
			a = a & d;
			rdd <= $urandom;
			op3(k == 0 ? `CMD_EEPROM_READ : k == 1 ? `CMD_CLOCK_READ : `CMD_PROT_READ, a, 0);
			chk(req_sp, k);
			chk(req_ad, (k != 0 && a == d) ? a : a + 8'd1);
			chk(h.rx, rdd);
		end
		k = n_req;
		op3(`CMD_PROT_READ, 8'h10, 8'h00);
		op3(`CMD_CLOCK_READ, 8'h60, 8'h00);
		chk(n_req, k);
		cmd(`CMD_SRAM_CLEAR);
		chk(n_ram, 1);
		pw <= $urandom % 8;
		pin[0] <= 1'b1;
		@(posedge clk);
		pin[0] <= 1'b0;
		repeat (20) @(posedge clk);
		pin[2:1] <= 2'h3;
		@(posedge clk);
		pin[3:2] <= 2'h2;
		repeat (20) @(posedge clk);
		chk(irq_oe, 1);
		pin[6:3] <= 4'h6;
		repeat (4) @(posedge clk);
		chk(irq_oe, 1);
		pin[4] <= 1'b0;
		repeat (4) @(posedge clk);
		chk(irq_oe, 0);
		conclude;
	end
endmodule
